//--- hw/store_extend_debug_exec.v
// Purpose: Executes the doubleword, halfword and conditional stores, sign extension
//          and the software debug breakpoint; APB control and interrupt registers
// Assumes: Operands arrive from the register files with the instruction strobe;
//          translation answers in the same cycle; one instruction per valid
// Notes:   Store words leave as one-cycle pulses, the second word one cycle later
//
// Function
// - Breakpoint always raises debug exception
// - Breakpoint in debug mode cause 0x9
// - Breakpoint code field ignored by hardware
// - Float double store: base plus offset
// - Double stores misaligned low three bits
// - Cop2 double store uses two registers
// - Flip address bit 2 per word
// - Indexed store: base plus index, low first
// - Indexed store present from release 2
// - Sign extend byte decode and result
// - Sign extend halfword result
// - Sign extends reserved before release 2
// - Halfword store: low sixteen bits
// - Halfword store misaligned on bit 0
// - Float double store exception set
// - Exception between link pair fails store
// - Link pair works noncoherent cached memory
// - Conditional store result one or zero
`timescale 1ns/1ps
`include "store_extend_debug_exec_defines.vh"

module store_extend_debug_exec #(
   parameter ARCH_RELEASE = 3'h2
) (
   input  wire        sys_clk_in,
   input  wire        rst_in,
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [11:0] paddr_in,
   input  wire [31:0] pwdata_in,
   output reg  [31:0] prdata_out,
   output reg         pready_out,
   output reg         pslverr_out,
   input  wire        instr_valid_in,
   input  wire [31:0] instr_in,
   input  wire [31:0] base_val_in,
   input  wire [31:0] index_val_in,
   input  wire [31:0] rt_val_in,
   input  wire [63:0] fpr_val_in,
   input  wire [31:0] cop2_lo_in,
   input  wire [31:0] cop2_hi_in,
   input  wire        fpu_usable_in,
   input  wire        cop2_usable_in,
   input  wire        debug_mode_flag_in,
   input  wire        big_endian_state_in,
   input  wire        reverse_endian_state_in,
   input  wire [31:0] trans_paddr_in,
   input  wire        trans_refill_in,
   input  wire        trans_invalid_in,
   input  wire        trans_modified_in,
   input  wire        watch_hit_in,
   input  wire        other_exc_in,
   output reg  [31:0] mem_vaddr_out,
   output reg  [31:0] trans_vaddr_out,
   output reg         trans_req_out,
   output reg  [31:0] mem_paddr_out,
   output reg  [31:0] mem_wdata_out,
   output reg  [3:0]  mem_be_out,
   output reg         mem_we_out,
   output reg         rd_we_out,
   output reg  [4:0]  rd_addr_out,
   output reg  [31:0] rd_data_out,
   output reg         exc_addr_err_out,
   output reg         exc_reserved_out,
   output reg         exc_cop_unusable_out,
   output reg         exc_trans_out,
   output reg         exc_watch_out,
   output reg         debug_exc_out,
   output reg         debug_mode_exc_out,
   output reg  [4:0]  debug_exception_cause_out,
   output reg         irq_out
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [31:0] sext16;
      input [15:0] v;
      begin
         sext16 = {{16{v[15]}}, v};
      end
   endfunction

   function [31:0] sext8;
      input [7:0] v;
      begin
         sext8 = {{24{v[7]}}, v};
      end
   endfunction

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire [5:0] opc = instr_in[`OPC_MSB:`OPC_LSB];
   wire [5:0] fn  = instr_in[`FN_MSB:`FN_LSB];
   wire [4:0] sa  = instr_in[`SA_MSB:`SA_LSB];
   wire [4:0] rs  = instr_in[`RS_MSB:`RS_LSB];
   wire [4:0] rt  = instr_in[`RT_MSB:`RT_LSB];
   wire [4:0] rd  = instr_in[`RD_MSB:`RD_LSB];
   wire       rel2 = (ARCH_RELEASE >= `ARCH_RELEASE_2);

   // Code field bits 25..6 take no part in decode
   wire software_debug_breakpoint_op = (opc == `OPC_MAJOR_GROUP3) &&
                                       (fn == `FN_SOFTWARE_DEBUG_BREAKPOINT_OP);
   wire store_double_fpr_op         = (opc == `OPC_STORE_DFPR);
   wire store_double_cop2_op        = (opc == `OPC_STORE_DCOP2);
   wire store_double_indexed_fpr_op = (opc == `OPC_COP1X) && (fn == `FN_STORE_DXFPR);
   wire store_half_op               = (opc == `OPC_STORE_HALF);
   wire bit_shuffle_group = (opc == `OPC_MAJOR_GROUP3) && (fn == `FN_BIT_SHUFFLE) &&
                            (rs == `RS_ZERO);
   wire sign_extend_byte_op = bit_shuffle_group && (sa == `SA_SIGN_BYTE);
   wire sign_extend_half_op = bit_shuffle_group && (sa == `SA_SIGN_HALF);
   wire linked_load_user_op = (opc == `OPC_MAJOR_GROUP3) && (fn == `FN_LL_USER);
   wire conditional_store_user_op = (opc == `OPC_SC_USER) && (fn == `FN_SC_USER);

   // ----------------------------------------
   // Address, alignment and exceptions
   // ----------------------------------------
   wire dbl = store_double_fpr_op | store_double_cop2_op | store_double_indexed_fpr_op;
   // Conditional store carries a 9-bit offset above the function field
   wire [31:0] vaddr = store_double_indexed_fpr_op ?
                       (base_val_in + index_val_in) :
                       conditional_store_user_op ?
                       (base_val_in + {{23{instr_in[15]}}, instr_in[15:7]}) :
                       (base_val_in + sext16(instr_in[15:0]));
   wire misalign = (dbl && (vaddr[2:0] != 3'h0)) ||
                   (store_half_op && vaddr[0]) ||
                   (conditional_store_user_op && (vaddr[1:0] != 2'h0));
   // Indexed form exists only from release 2
   wire reserved = ((sign_extend_byte_op | sign_extend_half_op) && !rel2) ||
                   (store_double_indexed_fpr_op && !rel2);
   wire cop_unusable = ((store_double_fpr_op | store_double_indexed_fpr_op) &&
                        !fpu_usable_in) ||
                       (store_double_cop2_op && !cop2_usable_in);
   wire is_store = dbl | store_half_op | conditional_store_user_op;
   wire trans_fault = trans_refill_in | trans_invalid_in | trans_modified_in;
   wire pre_fault = misalign | reserved | cop_unusable;
   wire fault = pre_fault || (is_store && (trans_fault || watch_hit_in));
   wire go = instr_valid_in && !fault && !other_exc_in;
   // Bit 2 flip for first word
   wire flip = big_endian_state_in ^ reverse_endian_state_in;
   wire [31:0] paddr_w0 = trans_paddr_in ^ {29'h0, flip, 2'h0};

   // ----------------------------------------
   // Link tracking
   // ----------------------------------------
   reg link_reg;
   reg second_pend_reg;
   reg [31:0] second_paddr_reg;
   reg [31:0] second_vaddr_reg;
   reg [31:0] second_data_reg;
   reg [3:0]  ctrl_reg;
   reg [`IRQ_W-1:0] irq_stat_reg;
   reg [`IRQ_W-1:0] irq_mask_reg;

   // Cacheability is not consulted, so noncoherent memory behaves alike
   wire any_exc = instr_valid_in && (fault || software_debug_breakpoint_op || other_exc_in);
   wire sc_ok = link_reg && !any_exc;
   wire [`IRQ_W-1:0] events = {
      instr_valid_in && conditional_store_user_op && !fault && !link_reg,
      instr_valid_in && reserved,
      instr_valid_in && misalign,
      instr_valid_in && software_debug_breakpoint_op};

   // ----------------------------------------
   // Execute
   // ----------------------------------------
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         link_reg <= 1'b0;
         second_pend_reg <= 1'b0;
         second_paddr_reg <= 32'h0;
         second_vaddr_reg <= 32'h0;
         second_data_reg <= 32'h0;
         mem_vaddr_out <= 32'h0;
         trans_vaddr_out <= 32'h0;
         trans_req_out <= 1'b0;
         mem_paddr_out <= 32'h0;
         mem_wdata_out <= 32'h0;
         mem_be_out <= 4'h0;
         mem_we_out <= 1'b0;
         rd_we_out <= 1'b0;
         rd_addr_out <= 5'h0;
         rd_data_out <= 32'h0;
         exc_addr_err_out <= 1'b0;
         exc_reserved_out <= 1'b0;
         exc_cop_unusable_out <= 1'b0;
         exc_trans_out <= 1'b0;
         exc_watch_out <= 1'b0;
         debug_exc_out <= 1'b0;
         debug_mode_exc_out <= 1'b0;
         debug_exception_cause_out <= 5'h0;
      end else begin
         trans_req_out <= instr_valid_in && is_store && !pre_fault;
         trans_vaddr_out <= vaddr;
         mem_we_out <= 1'b0;
         mem_be_out <= 4'h0;
         rd_we_out <= 1'b0;
         exc_addr_err_out <= instr_valid_in && misalign;
         exc_reserved_out <= instr_valid_in && reserved;
         exc_cop_unusable_out <= instr_valid_in && cop_unusable && !reserved;
         exc_trans_out <= instr_valid_in && is_store && !pre_fault && trans_fault;
         exc_watch_out <= instr_valid_in && is_store && !pre_fault && watch_hit_in;
         debug_exc_out <= instr_valid_in && software_debug_breakpoint_op;
         debug_mode_exc_out <= instr_valid_in && software_debug_breakpoint_op &&
                               debug_mode_flag_in;
         if (instr_valid_in && software_debug_breakpoint_op && debug_mode_flag_in)
            debug_exception_cause_out <= `DEBUG_CAUSE_BP;
         if (any_exc)
            link_reg <= 1'b0;
         second_pend_reg <= 1'b0;
         if (second_pend_reg) begin
            // Second word, bit 2 inverted again
            mem_we_out <= 1'b1;
            mem_be_out <= 4'hf;
            mem_paddr_out <= second_paddr_reg;
            mem_vaddr_out <= second_vaddr_reg;
            mem_wdata_out <= second_data_reg;
         end else if (go) begin
            // Faulting instructions never reach here
            if (dbl) begin
               mem_we_out <= 1'b1;
               mem_be_out <= 4'hf;
               mem_paddr_out <= paddr_w0;
               mem_vaddr_out <= vaddr;
               mem_wdata_out <= store_double_cop2_op ? cop2_lo_in : fpr_val_in[31:0];
               second_pend_reg <= 1'b1;
               second_paddr_reg <= paddr_w0 ^ `WORD_STEP;
               second_vaddr_reg <= vaddr + `WORD_STEP;
               second_data_reg <= store_double_cop2_op ? cop2_hi_in : fpr_val_in[63:32];
            end else if (store_half_op) begin
               mem_we_out <= 1'b1;
               mem_be_out <= (vaddr[1] ^ big_endian_state_in) ? 4'hc : 4'h3;
               mem_paddr_out <= trans_paddr_in;
               mem_vaddr_out <= vaddr;
               mem_wdata_out <= {rt_val_in[15:0], rt_val_in[15:0]};
            end else if (conditional_store_user_op) begin
               mem_we_out <= sc_ok;
               mem_be_out <= sc_ok ? 4'hf : 4'h0;
               mem_paddr_out <= trans_paddr_in;
               mem_vaddr_out <= vaddr;
               mem_wdata_out <= rt_val_in;
               rd_we_out <= 1'b1;
               rd_addr_out <= rt;
               rd_data_out <= {31'h0, sc_ok};
               link_reg <= 1'b0;
            end else if (sign_extend_byte_op) begin
               rd_we_out <= 1'b1;
               rd_addr_out <= rd;
               rd_data_out <= sext8(rt_val_in[7:0]);
            end else if (sign_extend_half_op) begin
               rd_we_out <= 1'b1;
               rd_addr_out <= rd;
               rd_data_out <= sext16(rt_val_in[15:0]);
            end else if (linked_load_user_op && !other_exc_in) begin
               link_reg <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // APB registers and interrupt
   // ----------------------------------------
   wire wr_acc = psel_in && penable_in && pwrite_in;
   wire rd_acc = psel_in && !penable_in && !pwrite_in;

   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_reg <= `CTRL_RESET;
         irq_stat_reg <= {`IRQ_W{1'b0}};
         irq_mask_reg <= {`IRQ_W{1'b0}};
         prdata_out <= 32'h0;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         pready_out <= psel_in && !penable_in;
         pslverr_out <= psel_in && !penable_in &&
                        (paddr_in != `ADDR_CTRL) && (paddr_in != `ADDR_STATUS) &&
                        (paddr_in != `ADDR_IRQ_STAT) && (paddr_in != `ADDR_IRQ_MASK);
         if (wr_acc && pready_out && paddr_in == `ADDR_CTRL)
            ctrl_reg <= pwdata_in[3:0];
         if (wr_acc && pready_out && paddr_in == `ADDR_IRQ_MASK)
            irq_mask_reg <= pwdata_in[`IRQ_W-1:0];
         // Set wins over write-one-to-clear
         if (wr_acc && pready_out && paddr_in == `ADDR_IRQ_STAT)
            irq_stat_reg <= (irq_stat_reg & ~pwdata_in[`IRQ_W-1:0]) | (events & ctrl_reg);
         else
            irq_stat_reg <= irq_stat_reg | (events & ctrl_reg);
         irq_out <= |(irq_stat_reg & ~irq_mask_reg);
         if (rd_acc) begin
            case (paddr_in)
               `ADDR_CTRL:     prdata_out <= {28'h0, ctrl_reg};
               `ADDR_STATUS:   prdata_out <= {29'h0, second_pend_reg, debug_mode_flag_in,
                                              link_reg};
               `ADDR_IRQ_STAT: prdata_out <= {28'h0, irq_stat_reg};
               `ADDR_IRQ_MASK: prdata_out <= {28'h0, irq_mask_reg};
               default:        prdata_out <= 32'h0;
            endcase
         end
      end
   end

endmodule

//--- include/store_extend_debug_exec_defines.vh
// Purpose: Constants for the store, sign-extend and debug breakpoint execution unit
// Assumes: 32-bit instruction words, 32-bit general registers
// Notes:   Offsets are byte addresses on the register bus
`ifndef STORE_EXTEND_DEBUG_EXEC_DEFINES_VH
`define STORE_EXTEND_DEBUG_EXEC_DEFINES_VH

// ----------------------------------------
// Instruction fields and encodings
// ----------------------------------------
`define OPC_MSB           31
`define OPC_LSB           26
`define RS_MSB            25
`define RS_LSB            21
`define RT_MSB            20
`define RT_LSB            16
`define RD_MSB            15
`define RD_LSB            11
`define SA_MSB            10
`define SA_LSB            6
`define FN_MSB            5
`define FN_LSB            0
`define OPC_SPECIAL       6'h00
`define OPC_MAJOR_GROUP3  6'h1f
`define OPC_COP1X         6'h13
`define OPC_STORE_HALF    6'h29
`define OPC_STORE_DFPR    6'h3d
`define OPC_STORE_DCOP2   6'h3e
`define OPC_SC_USER       6'h1f
`define FN_BIT_SHUFFLE    6'h20
`define FN_SC_USER        6'h1e
`define FN_LL_USER        6'h2e
`define FN_SOFTWARE_DEBUG_BREAKPOINT_OP          6'h3f
`define FN_STORE_DXFPR    6'h09
`define SA_SIGN_BYTE      5'h10
`define SA_SIGN_HALF      5'h18
`define RS_ZERO           5'h00
`define DEBUG_CAUSE_BP    5'h09
`define ARCH_RELEASE_2    3'h2
`define WORD_STEP         32'h00000004
`define ENDIAN_BIT        2

// ----------------------------------------
// Register map
// ----------------------------------------
`define ADDR_CTRL         12'h000
`define ADDR_STATUS       12'h004
`define ADDR_IRQ_STAT     12'h008
`define ADDR_IRQ_MASK     12'h00c
`define CTRL_RESET        4'h0
`define IRQ_W             4
`define IRQ_DEBUG         0
`define IRQ_ADDR_ERR      1
`define IRQ_RESERVED      2
`define IRQ_SC_FAIL       3

`endif

//--- dv/xlate_model.sv
// Purpose: Translation stand-in, answers in the request cycle
// Assumes: Effective address formed as the execution unit does
// Notes:   Fixed remap of one high bit; faults on command
`timescale 1ns/1ps
`include "store_extend_debug_exec_defines.vh"
module xlate_model #(
   parameter [31:0] PA_FLIP = 32'h40000000
) (
   input  wire [31:0] instr_in,
   input  wire [31:0] base_in,
   input  wire [31:0] index_in,
   input  wire [2:0]  fault_in,
   output wire [31:0] paddr_out,
   output wire        refill_out,
   output wire        invalid_out,
   output wire        modified_out
);
   wire [5:0]  opc = instr_in[31:26];
   wire [31:0] va  = (opc == `OPC_COP1X) ? base_in + index_in :
                     (opc == `OPC_SC_USER) ? base_in + {{23{instr_in[15]}}, instr_in[15:7]} :
                     base_in + {{16{instr_in[15]}}, instr_in[15:0]};
   assign paddr_out    = va ^ PA_FLIP;
   assign refill_out   = fault_in[0];
   assign invalid_out  = fault_in[1];
   assign modified_out = fault_in[2];
endmodule

//--- dv/store_extend_debug_exec_chk.sv
// Purpose: Port assertions for the execution unit
// Assumes: One clock, asynchronous high reset
// Notes:   Bound to every instance
`timescale 1ns/1ps
`include "store_extend_debug_exec_defines.vh"
module store_extend_debug_exec_chk #(
   parameter ARCH_RELEASE = 3'h2
) (
   input wire        sys_clk_in,
   input wire        rst_in,
   input wire        instr_valid_in,
   input wire [31:0] instr_in,
   input wire [31:0] base_val_in,
   input wire [31:0] rt_val_in,
   input wire [63:0] fpr_val_in,
   input wire        fpu_usable_in,
   input wire        debug_mode_flag_in,
   input wire        trans_refill_in,
   input wire        trans_invalid_in,
   input wire        trans_modified_in,
   input wire        watch_hit_in,
   input wire        other_exc_in,
   input wire        mem_we_out,
   input wire [31:0] mem_wdata_out,
   input wire [31:0] mem_paddr_out,
   input wire        exc_addr_err_out,
   input wire        rd_we_out,
   input wire [31:0] rd_data_out,
   input wire        debug_exc_out,
   input wire        debug_mode_exc_out,
   input wire [4:0]  debug_exception_cause_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   wire [5:0]  opc = instr_in[31:26];
   wire [31:0] ea  = base_val_in + {{16{instr_in[15]}}, instr_in[15:0]};
   wire flt = trans_refill_in | trans_invalid_in | trans_modified_in | watch_hit_in | other_exc_in;
   wire bp  = instr_valid_in && opc == `OPC_MAJOR_GROUP3 && instr_in[5:0] == `FN_SOFTWARE_DEBUG_BREAKPOINT_OP;
   wire sdc = instr_valid_in && opc == `OPC_STORE_DFPR && fpu_usable_in;
   wire sh  = instr_valid_in && opc == `OPC_STORE_HALF;
   wire ext = instr_valid_in && opc == `OPC_MAJOR_GROUP3 && instr_in[25:21] == 5'h00 &&
              instr_in[5:0] == `FN_BIT_SHUFFLE && ARCH_RELEASE >= 3'h2;
   property p_bp; bp && !debug_mode_flag_in |=> debug_exc_out && !debug_mode_exc_out; endproperty
   property p_bp_dm; bp && debug_mode_flag_in |=> debug_mode_exc_out &&
      debug_exception_cause_out == 5'h09; endproperty
   property p_dbl_mis; sdc && ea[2:0] != 3'h0 |=> exc_addr_err_out && !mem_we_out ##1 !mem_we_out;
   endproperty
   property p_dbl; sdc && ea[2:0] == 3'h0 && !flt |=> mem_we_out &&
      mem_wdata_out == $past(fpr_val_in[31:0]) ##1 mem_we_out &&
      mem_wdata_out == $past(fpr_val_in[63:32], 2) &&
      mem_paddr_out == ($past(mem_paddr_out) ^ 32'h00000004); endproperty
   property p_seb; ext && instr_in[10:6] == `SA_SIGN_BYTE |=> rd_we_out &&
      rd_data_out == {{24{$past(rt_val_in[7])}}, $past(rt_val_in[7:0])}; endproperty
   property p_seh; ext && instr_in[10:6] == `SA_SIGN_HALF |=> rd_we_out &&
      rd_data_out == {{16{$past(rt_val_in[15])}}, $past(rt_val_in[15:0])}; endproperty
   property p_sh_mis; sh && ea[0] |=> exc_addr_err_out && !mem_we_out; endproperty
   property p_sh; sh && !ea[0] && !flt |=> mem_we_out &&
      mem_wdata_out == {2{$past(rt_val_in[15:0])}}; endproperty
   property p_flt; instr_valid_in && flt |=> !mem_we_out ##1 !mem_we_out; endproperty
   a_bp: assert property (p_bp) else $error("breakpoint gave no debug exception");
   a_bp_dm: assert property (p_bp_dm) else $error("debug mode breakpoint wrong");
   a_dbl_mis: assert property (p_dbl_mis) else $error("misaligned double store");
   a_dbl: assert property (p_dbl) else $error("double store words wrong");
   a_seb: assert property (p_seb) else $error("byte sign extension wrong");
   a_seh: assert property (p_seh) else $error("half sign extension wrong");
   a_sh_mis: assert property (p_sh_mis) else $error("misaligned half store");
   a_sh: assert property (p_sh) else $error("half store data wrong");
   a_flt: assert property (p_flt) else $error("write on faulting store");
   c_dm: cover property (bp && debug_mode_flag_in);
   c_dbl: cover property (sdc ##1 mem_we_out ##1 mem_we_out);
   c_ext: cover property (ext ##1 rd_we_out);
endmodule
bind store_extend_debug_exec store_extend_debug_exec_chk #(.ARCH_RELEASE(ARCH_RELEASE)) u_chk (
   .sys_clk_in, .rst_in, .instr_valid_in, .instr_in, .base_val_in, .rt_val_in, .fpr_val_in,
   .fpu_usable_in, .debug_mode_flag_in, .trans_refill_in, .trans_invalid_in,
   .trans_modified_in, .watch_hit_in, .other_exc_in, .mem_we_out, .mem_wdata_out,
   .mem_paddr_out, .exc_addr_err_out, .rd_we_out, .rd_data_out, .debug_exc_out,
   .debug_mode_exc_out, .debug_exception_cause_out);

//--- dv/store_extend_debug_exec_test.sv
// Purpose: Directed bench for the execution unit
// Assumes: Partner remaps addresses by flipping bit 30
// Notes:   At least one idle cycle between instructions
`timescale 1ns/1ps
`include "store_extend_debug_exec_defines.vh"
module store_extend_debug_exec_test;
   reg         sys_clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
   reg         instr_valid_in = 0, fpu_usable_in = 1, cop2_usable_in = 1;
   reg         debug_mode_flag_in = 0, big_endian_state_in = 0, reverse_endian_state_in = 0;
   reg         watch_hit_in = 0, other_exc_in = 0, dm_v = 0, be_v = 0, fu_v = 1, wh_v = 0, err;
   reg  [11:0] paddr_in = 0;
   reg  [31:0] pwdata_in = 0, instr_in = 0, base_val_in = 0, index_val_in = 0, rt_val_in = 0;
   reg  [31:0] cop2_lo_in = 0, cop2_hi_in = 0, rd, pa;
   reg  [63:0] fpr_val_in = 0;
   reg  [2:0]  fault = 0, ft_v = 0;
   wire [31:0] trans_paddr_in, prdata_out, mem_vaddr_out, trans_vaddr_out, mem_paddr_out;
   wire [31:0] mem_wdata_out, rd_data_out;
   wire        trans_refill_in, trans_invalid_in, trans_modified_in, pready_out, pslverr_out;
   wire        trans_req_out, mem_we_out, rd_we_out, exc_addr_err_out, exc_reserved_out;
   wire        exc_cop_unusable_out, exc_trans_out, exc_watch_out, debug_exc_out;
   wire        debug_mode_exc_out, irq_out;
   wire [3:0]  mem_be_out;
   wire [4:0]  rd_addr_out, debug_exception_cause_out;
   integer     n_fail = 0, num_checks = 0, i, k;
   localparam [63:0] F = 64'h89abcdef01234567;

   store_extend_debug_exec #(.ARCH_RELEASE(3'h2)) dut (.*);
   xlate_model xm (.instr_in(instr_in), .base_in(base_val_in), .index_in(index_val_in),
      .fault_in(fault), .paddr_out(trans_paddr_in), .refill_out(trans_refill_in),
      .invalid_out(trans_invalid_in), .modified_out(trans_modified_in));

   always #2 sys_clk_in = ~sys_clk_in;

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task chk(input [127:0] nm, input [31:0] seen, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD %0s exp %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task apb(input wr, input [11:0] a, input [31:0] d);
      begin
         @(posedge sys_clk_in);
         psel_in <= 1;
         pwrite_in <= wr;
         paddr_in <= a;
         pwdata_in <= d;
         @(posedge sys_clk_in);
         penable_in <= 1;
         k = 0;
         @(posedge sys_clk_in);
         while (pready_out !== 1'b1 && k < 20) begin
            k = k + 1;
            @(posedge sys_clk_in);
         end
         rd = prdata_out;
         err = pslverr_out;
         psel_in <= 0;
         penable_in <= 0;
         if (k == 20) chk("pready", 0, 1);
      end
   endtask
   // Issue one instruction; returns just after its answer edge
   task run(input [31:0] ins, input [31:0] b, input [31:0] x, input [31:0] r, input [63:0] f);
      begin
         @(posedge sys_clk_in);
         instr_in <= ins;
         base_val_in <= b;
         index_val_in <= x;
         rt_val_in <= r;
         fpr_val_in <= f;
         cop2_lo_in <= f[31:0];
         cop2_hi_in <= f[63:32];
         debug_mode_flag_in <= dm_v;
         big_endian_state_in <= be_v;
         fpu_usable_in <= fu_v;
         fault <= ft_v;
         watch_hit_in <= wh_v;
         instr_valid_in <= 1;
         @(posedge sys_clk_in);
         instr_valid_in <= 0;
         #1;
      end
   endtask
   task nxt;
      begin
         @(posedge sys_clk_in);
         #1;
      end
   endtask
   task conclude;
      begin
         $display("checks %0d mismatches %0d", num_checks, n_fail);
         if (n_fail == 0 && num_checks > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   initial begin
      #100000;
      n_fail = n_fail + 1;
      conclude;
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge sys_clk_in);
      rst_in <= 0;
      apb(0, 12'h000, 0);
      chk("ctrl_reset", rd, 0);
      apb(1, 12'h000, 32'hf);
      apb(0, 12'h000, 0);
      chk("ctrl", rd, 32'hf);
      apb(0, 12'h010, 0);
      chk("unmapped_err", err, 1);
      apb(1, 12'h00c, 0);
      $display("test registers done");
      run({`OPC_MAJOR_GROUP3, 10'h003, 5'h04, `SA_SIGN_BYTE, `FN_BIT_SHUFFLE}, 0, 0, 32'h12348081, 0);
      chk("seb", rd_data_out, 32'hffffff81);
      chk("seb_rd", rd_addr_out, 4);
      run({`OPC_MAJOR_GROUP3, 10'h003, 5'h04, `SA_SIGN_HALF, `FN_BIT_SHUFFLE}, 0, 0, 32'h12348081, 0);
      chk("seh", rd_data_out, 32'hffff8081);
      $display("test extend done");
      for (i = 0; i < 4; i = i + 1) begin
         be_v = (i != 3);
         run(i == 2 ? {`OPC_COP1X, 20'h20000, `FN_STORE_DXFPR} : {i == 1 ? `OPC_STORE_DCOP2 :
             `OPC_STORE_DFPR, 10'h020, 16'h0010}, 32'h1000, 32'h10, 0, F);
         pa = 32'h40001010 ^ {29'h0, be_v, 2'h0};
         chk("dbl_we0", mem_we_out, 1);
         chk("dbl_lo", mem_wdata_out, F[31:0]);
         chk("dbl_pa0", mem_paddr_out, pa);
         nxt;
         chk("dbl_hi", mem_wdata_out, F[63:32]);
         chk("dbl_pa1", mem_paddr_out, pa ^ 32'h4);
         chk("dbl_va1", mem_vaddr_out, 32'h1014);
      end
      for (i = 0; i < 3; i = i + 1) begin
         run({`OPC_STORE_DFPR, 10'h020, 16'h0001 << i}, 32'h1000, 0, 0, F);
         chk("dbl_mis", exc_addr_err_out, 1);
         nxt;
         chk("dbl_mis_we", mem_we_out, 0);
      end
      for (i = 0; i < 4; i = i + 1) begin
         ft_v = (i < 3) ? 3'h1 << i : 3'h0;
         fu_v = (i < 3);
         run({`OPC_STORE_DFPR, 10'h020, 16'h0010}, 32'h1000, 0, 0, F);
         chk("dbl_exc", i < 3 ? exc_trans_out : exc_cop_unusable_out, 1);
         nxt;
         chk("dbl_exc_we", mem_we_out, 0);
      end
      ft_v = 0;
      fu_v = 1;
      be_v = 0;
      run({`OPC_STORE_HALF, 10'h022, 16'h0002}, 32'h1000, 0, 32'h1234abcd, 0);
      chk("sh_data", mem_wdata_out, 32'habcdabcd);
      chk("sh_be", mem_be_out, 4'hc);
      chk("sh_treq", trans_req_out, 1);
      wh_v = 1;
      run({`OPC_STORE_HALF, 10'h022, 16'h0002}, 32'h1000, 0, 32'h1234abcd, 0);
      chk("sh_watch", exc_watch_out, 1);
      chk("sh_watch_we", mem_we_out, 0);
      wh_v = 0;
      run({`OPC_STORE_HALF, 10'h022, 16'h0003}, 32'h1000, 0, 32'h1234abcd, 0);
      chk("sh_mis", exc_addr_err_out, 1);
      chk("sh_mis_we", mem_we_out, 0);
      $display("test stores done");
      apb(1, 12'h008, 32'hf);
      for (i = 0; i < 2; i = i + 1) begin
         dm_v = i;
         run({`OPC_MAJOR_GROUP3, 20'habcde, `FN_SOFTWARE_DEBUG_BREAKPOINT_OP}, 0, 0, 0, 0);
         chk("bp_exc", i ? debug_mode_exc_out : debug_exc_out, 1);
         if (i) chk("bp_cause", debug_exception_cause_out, `DEBUG_CAUSE_BP);
      end
      dm_v = 0;
      apb(0, 12'h008, 0);
      chk("irq_stat", rd, 32'h1);
      chk("irq_on", irq_out, 1);
      apb(1, 12'h00c, 32'h1);
      nxt;
      chk("irq_masked", irq_out, 0);
      apb(1, 12'h008, 32'h1);
      apb(0, 12'h008, 0);
      chk("irq_clear", rd, 0);
      $display("test debug done");
      for (i = 0; i < 2; i = i + 1) begin
         run({`OPC_MAJOR_GROUP3, 10'h025, 10'h0, `FN_LL_USER}, 32'h1000, 0, 0, 0);
         if (i) run({`OPC_STORE_HALF, 10'h022, 16'h0001}, 32'h1000, 0, 0, 0);
         run({`OPC_MAJOR_GROUP3, 10'h025, 10'h0, `FN_SC_USER}, 32'h1000, 0, 32'h5555aaaa, 0);
         chk("sc_we", mem_we_out, !i);
         chk("sc_result", rd_data_out, !i);
      end
      $display("test link done");
      conclude;
   end
endmodule
